/* File: src/gpm_regs.vh */
// Register offset, field positions, reset value and mux codes of the general pin mux
`ifndef GPM_REGS_VH
`define GPM_REGS_VH

// Register address on the internal register port
`define GPM_CFG_ADDR        8'h78
// Register width and reset value
`define GPM_CFG_W           24
`define GPM_CFG_RESET       24'h000000
// Bits that software may set; all others are reserved and held at zero
`define GPM_CFG_WMASK       24'h419fc7

// Field positions
`define GPM_REROUTE_BIT     22
`define GPM_P2_IBUF_BIT     16
`define GPM_P2_OBUF_BIT     15
`define GPM_P1_OBUF_BIT     12
`define GPM_P2_SEL_HI       11
`define GPM_P2_SEL_LO       9
`define GPM_P1_SEL_HI       8
`define GPM_P1_SEL_LO       6
`define GPM_P3_SEL_HI       2
`define GPM_P3_SEL_LO       0

// Output select codes
`define GPM_SEL_GND         3'h0
`define GPM_SEL_INT0        3'h2
`define GPM_SEL_INT1        3'h3
`define GPM_SEL_ALT         3'h7

`endif

/* File: src/gpm_out_sel.v */
// Output select for one general pin: ground, two shared internal outputs or a pin-specific source
`default_nettype none
`include "gpm_regs.vh"

module gpm_out_sel (
  input  wire [2:0] i_sel,        // Select code from the configuration register
  input  wire       i_int0,       // Internal output zero
  input  wire       i_int1,       // Internal output one
  input  wire       i_alt,        // Pin-specific source for code 7
  output reg        o_val         // Selected level
);

  // Decode the select; unlisted codes fall to ground so the pin never floats
  always @* begin
    case (i_sel)
      `GPM_SEL_GND:  o_val = 1'b0;
      `GPM_SEL_INT0: o_val = i_int0;
      `GPM_SEL_INT1: o_val = i_int1;
      `GPM_SEL_ALT:  o_val = i_alt;
      default:       o_val = 1'b0;
    endcase
  end

endmodule // gpm_out_sel

`default_nettype wire

/* File: src/gpm_pin_mux.v */
// General pin output multiplexer with its configuration register
//
// How it works
// - Reset clears register: ground selected, buffers off
// - Reserved bits read zero, software writes zero
// - Reroute bit moves pin three to aux data
// - Rerouted signal driven inverted, active low
// - Pin two input buffer follows its enable
// - Pin two output drives only when enabled
// - Pin one output drives only when enabled
// - Pin two select: ground, int0, int1, tx0 enable
// - Pin one select: ground, int0, int1, illum clock
// - Pin three select: ground, int0, int1, int2
`default_nettype none
`include "gpm_regs.vh"

module gpm_pin_mux (
  input  wire        i_clk_sys,                              // Device clock, 125 MHz
  input  wire        i_nrst,                                 // Async reset, active low
  // Internal register port
  input  wire [7:0]  i_reg_addr,                             // Register address
  input  wire        i_reg_wr,                               // Write strobe, one cycle
  input  wire [23:0] i_reg_wdata,                            // Write data
  input  wire        i_reg_rd,                               // Read strobe, one cycle
  output reg  [23:0] o_reg_rdata,                            // Read data, one cycle later
  output reg         o_reg_rvalid,                           // Read data valid pulse
  // Internal signal sources
  input  wire        i_internal_output_zero,                 // Shared source for code 2
  input  wire        i_internal_output_one,                  // Shared source for code 3
  input  wire        i_internal_output_two,                  // Pin three code 7
  input  wire        i_transmitter_zero_illumination_enable, // Pin two code 7
  input  wire        i_illumination_modulation_clock,        // Pin one code 7
  // General pin one
  output reg         o_general_pin_one_out,                  // Pin one output level
  output reg         o_general_pin_one_oe,                   // Pin one output enable
  // General pin two
  input  wire        i_general_pin_two_in,                   // Pin two input level
  output reg         o_general_pin_two_out,                  // Pin two output level
  output reg         o_general_pin_two_oe,                   // Pin two output enable
  output reg         o_reference_clock_in,                   // Gated pin two input path
  // General pin three
  output reg         o_general_pin_three_out,                // Pin three output level
  // Auxiliary host data pin, open drain with external pull-up
  output reg         o_aux_data_out,                         // Always low when driven
  output reg         o_aux_data_oe                           // Pulls the line low
);

  // Configuration register, reserved bits held at zero
  reg  [23:0] cfg_r;
  reg  [23:0] cfg_nxt;

  // Field views
  wire        reroute_en;
  wire        pin_two_input_buffer_enable;
  wire        pin_two_output_buffer_enable;
  wire        pin_one_output_buffer_enable;
  wire [2:0]  pin_two_output_select;
  wire [2:0]  pin_one_output_select;
  wire [2:0]  pin_three_output_select;

  // Per-pin selected levels, indexed by pin minus one
  wire [2:0]  sel_code [0:2];
  wire [2:0]  alt_src;
  wire [2:0]  pin_val;

  // Address match, used by both the write and the read path
  function addr_hit;
    input [7:0] addr;
    begin
      addr_hit = (addr == `GPM_CFG_ADDR);
    end
  endfunction

  assign reroute_en                   = cfg_r[`GPM_REROUTE_BIT];
  assign pin_two_input_buffer_enable  = cfg_r[`GPM_P2_IBUF_BIT];
  assign pin_two_output_buffer_enable = cfg_r[`GPM_P2_OBUF_BIT];
  assign pin_one_output_buffer_enable = cfg_r[`GPM_P1_OBUF_BIT];
  assign pin_one_output_select        = cfg_r[`GPM_P1_SEL_HI:`GPM_P1_SEL_LO];
  assign pin_two_output_select        = cfg_r[`GPM_P2_SEL_HI:`GPM_P2_SEL_LO];
  assign pin_three_output_select      = cfg_r[`GPM_P3_SEL_HI:`GPM_P3_SEL_LO];

  // Table of select codes and code-7 sources, one entry per pin
  assign sel_code[0] = pin_one_output_select;
  assign sel_code[1] = pin_two_output_select;
  assign sel_code[2] = pin_three_output_select;
  assign alt_src[0]  = i_illumination_modulation_clock;
  assign alt_src[1]  = i_transmitter_zero_illumination_enable;
  assign alt_src[2]  = i_internal_output_two;

  // One selector per pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      gpm_out_sel u_sel (
        .i_sel  (sel_code[gi]),
        .i_int0 (i_internal_output_zero),
        .i_int1 (i_internal_output_one),
        .i_alt  (alt_src[gi]),
        .o_val  (pin_val[gi])
      );
    end
  endgenerate

  // Next register value; reserved bits are masked so they can never be set
  always @* begin
    cfg_nxt = cfg_r;
    if (i_reg_wr && addr_hit(i_reg_addr)) begin
      cfg_nxt = i_reg_wdata & `GPM_CFG_WMASK;
    end
  end

  // Register storage
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_r <= `GPM_CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Read path: a read in the same cycle as a write returns the old value
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata  <= 24'h000000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd && addr_hit(i_reg_addr)) begin
        o_reg_rdata <= cfg_r;
      end else begin
        o_reg_rdata <= 24'h000000;  // Unmapped address reads zero
      end
    end
  end

  // Pin outputs, registered so every pin changes on a clock edge only;
  // the cost is one cycle of delay on every routed source
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_general_pin_one_out   <= 1'b0;
      o_general_pin_one_oe    <= 1'b0;
      o_general_pin_two_out   <= 1'b0;
      o_general_pin_two_oe    <= 1'b0;
      o_reference_clock_in    <= 1'b0;
      o_general_pin_three_out <= 1'b0;
      o_aux_data_out          <= 1'b0;
      o_aux_data_oe           <= 1'b0;
    end else begin
      // Pin one
      o_general_pin_one_out <= pin_val[0];
      o_general_pin_one_oe  <= pin_one_output_buffer_enable;
      // Pin two
      o_general_pin_two_out <= pin_val[1];
      o_general_pin_two_oe  <= pin_two_output_buffer_enable;
      // Input buffer off means the reference path sees a steady low
      o_reference_clock_in  <= pin_two_input_buffer_enable & i_general_pin_two_in;
      // Pin three falls to ground while its function is on the aux pin
      if (reroute_en) begin
        o_general_pin_three_out <= 1'b0;
      end else begin
        o_general_pin_three_out <= pin_val[2];
      end
      // Open drain: a high function level pulls the line low, giving the inversion
      o_aux_data_out <= 1'b0;
      o_aux_data_oe  <= reroute_en & pin_val[2];
    end
  end

endmodule // gpm_pin_mux

`default_nettype wire

/* File: bench/gpm_checker.sv */
// Assertion checker for the general pin output mux
`default_nettype none
module gpm_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic [23:0] i_reg_wdata,
  input wire logic [23:0] o_reg_rdata,
  input wire logic        o_reg_rvalid,
  input wire logic        i_general_pin_two_in,
  input wire logic        o_general_pin_one_oe,
  input wire logic        o_general_pin_two_oe,
  input wire logic        o_reference_clock_in,
  input wire logic        o_general_pin_three_out,
  input wire logic        o_aux_data_out,
  input wire logic        o_aux_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // Write taken at the mapped address; pins follow two edges later
  sequence s_cfg_wr;
    i_reg_wr && i_reg_addr == 8'h78;
  endsequence
  a_reset_quiet: assert property (!$past(i_nrst) |-> !o_general_pin_one_oe &&
    !o_general_pin_two_oe && !o_aux_data_oe) else $error("drivers on after reset");
  a_reserved_zero: assert property (o_reg_rvalid |->
    (o_reg_rdata & 24'hbe6038) == 24'h0) else $error("reserved bits read back set");
  a_pin_one_oe: assert property (s_cfg_wr |-> ##2
    o_general_pin_one_oe == $past(i_reg_wdata[12], 2)) else $error("pin one enable wrong");
  a_pin_two_oe: assert property (s_cfg_wr |-> ##2
    o_general_pin_two_oe == $past(i_reg_wdata[15], 2)) else $error("pin two enable wrong");
  a_aux_active_low: assert property (o_aux_data_oe |->
    !o_aux_data_out && !o_general_pin_three_out) else $error("aux pin not active low");
  a_reroute_gate: assert property (s_cfg_wr and !i_reg_wdata[22] |->
    ##2 !o_aux_data_oe) else $error("aux pin driven without reroute");
  a_refclk_path: assert property (o_reference_clock_in |->
    $past(i_general_pin_two_in)) else $error("reference input not from pin");
  a_refclk_gate: assert property (s_cfg_wr and !i_reg_wdata[16] |->
    ##2 !o_reference_clock_in) else $error("reference input not gated");
endmodule // gpm_checker
bind gpm_pin_mux gpm_checker chk_u (.i_clk_sys, .i_nrst, .i_reg_addr, .i_reg_wr,
  .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_general_pin_two_in, .o_general_pin_one_oe,
  .o_general_pin_two_oe, .o_reference_clock_in, .o_general_pin_three_out, .o_aux_data_out,
  .o_aux_data_oe);
`default_nettype wire

/* File: bench/gpm_board_model.sv */
// Board-side model: reference clock on pin two, pull-up on aux data
`default_nettype none
module gpm_board_model (
  input  wire logic i_clk_sys,
  input  wire logic i_ref_run,
  input  wire logic i_aux_data_out,
  input  wire logic i_aux_data_oe,
  output var  logic o_ref_clk,
  output wire logic o_aux_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_ref_clk = 1'b0;
  // Clock rests low between bursts so a stale level never looks like a clock
  always @(posedge i_clk_sys) o_ref_clk <= i_ref_run ? !o_ref_clk : 1'b0;
  // Pull-up holds the line high unless the device pulls it low
  assign o_aux_wire = i_aux_data_oe ? i_aux_data_out : 1'b1;
endmodule // gpm_board_model
`default_nettype wire

/* File: bench/test_general_pin_output_mux.sv */
// Self-checking testbench for the general pin output mux
`default_nettype none
module test_general_pin_output_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, wr_s, rd_s, rvalid, run, p1, e1, p2, e2, rck, p3, ao, ae, pin2, lv;
  logic [7:0]  addr;
  logic [23:0] wdata, rdata;
  logic [3:0]  src;       // Int0, int1, illum clock, tx0 enable
  int          mismatches = 0;
  int          samples_checked = 0;
  gpm_pin_mux dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wr(wr_s),
    .i_reg_wdata(wdata), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_internal_output_zero(src[0]), .i_internal_output_one(src[1]),
    .i_internal_output_two(src[2] ^ src[3]), .i_transmitter_zero_illumination_enable(src[3]),
    .i_illumination_modulation_clock(src[2]), .o_general_pin_one_out(p1),
    .o_general_pin_one_oe(e1), .i_general_pin_two_in(pin2), .o_general_pin_two_out(p2),
    .o_general_pin_two_oe(e2), .o_reference_clock_in(rck), .o_general_pin_three_out(p3),
    .o_aux_data_out(ao), .o_aux_data_oe(ae));
  gpm_board_model board_u (.i_clk_sys(clk), .i_ref_run(run), .i_aux_data_out(ao),
    .i_aux_data_oe(ae), .o_ref_clk(pin2), .o_aux_wire(lv));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Expected mux output; unlisted codes give ground
  function automatic logic ev(input int c, input logic a, input logic b, input logic alt);
    return c == 2 ? a : c == 3 ? b : c == 7 ? alt : 1'b0;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk) begin
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
    end
    @(posedge clk) wr_s <= 1'b0;
  endtask
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask
  // Read the mapped register; answer stands one cycle after the strobe
  task automatic rd(input logic [23:0] exp);
    @(posedge clk) begin
      addr <= 8'h78;
      rd_s <= 1'b1;
    end
    @(posedge clk) rd_s <= 1'b0;
    @(negedge clk);
    chk("rvalid", 24'h1, rvalid);
    chk("rdata", exp, rdata);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20us;
    mismatches++;
    finish_test();
  end
  initial begin
    {nrst, wr_s, rd_s, run, addr, wdata, src} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    settle();
    chk("oe1", 24'h0, e1);
    chk("oe2", 24'h0, e2);
    rd(24'h0);
    wr(8'h78, 24'hffffff);
    rd(24'h419fc7);
    wr(8'h77, 24'h0);
    rd(24'h419fc7);
    // Every code on all three pins against every source pattern
    for (int c = 0; c < 8; c++) begin
      wr(8'h78, {8'h01, 4'h9, c[2:0], c[2:0], 3'h0, c[2:0]});
      for (int p = 0; p < 16; p++) begin
        @(posedge clk) src <= p[3:0];
        settle();
        chk("pin1", ev(c, p[0], p[1], p[2]), p1);
        chk("pin2", ev(c, p[0], p[1], p[3]), p2);
        chk("pin3", ev(c, p[0], p[1], p[2] ^ p[3]), p3);
      end
    end
    wr(8'h78, 24'h400007);
    for (int p = 0; p < 8; p += 4) begin
      @(posedge clk) src <= p[3:0];
      settle();
      chk("aux_oe", p[2], ae);
      chk("aux_wire", !p[2], lv);
      chk("pin3", 24'h0, p3);
    end
    wr(8'h78, 24'h010000);
    @(posedge clk) run <= 1'b1;
    repeat (4) begin
      settle();
      chk("refclk", !pin2, rck);
    end
    wr(8'h78, 24'h0);
    settle();
    chk("refclk_off", 24'h0, rck);
    chk("oe1", 24'h0, e1);
    chk("oe2", 24'h0, e2);
    finish_test();
  end
endmodule // test_general_pin_output_mux
`default_nettype wire
